/* core/nvb_pkg.sv */
// Summary of operation
// - a separate 512-byte store; each access moves exactly one byte.
// - a read stalls the core for four clock cycles.
// - a write stalls the core for two clock cycles.
// - address holds 9 bits in 8..0; bits 15..9 read zero.
// - addresses 0 to 511 each select one distinct byte.
// - address has no reset value; software writes it before any access.
// - a write stores the data register byte at the addressed location.
// - a read loads the data register from the addressed location.
// - address, data and control registers sit in the I/O register space.
// - writes are self-timed and completion is visible to software.
// - a write starts only after a protective enable sequence.
// - write strobe works only within four cycles of master enable.
// - write strobe stays set during a write, cleared by hardware after.
// - read strobe reads at once; no reads or address changes mid-write.
// - a write lasts 8448 cycles of a 1 MHz calibrated oscillator.
package nvb_pkg;
   localparam int unsigned NVB_DEPTH      = 512;
   localparam int unsigned NVB_AW         = 9;
   // i/o register space offsets, arbitrary within the block's own window
   localparam logic [5:0] NVB_OFS_CTRL   = 6'h1c;
   localparam logic [5:0] NVB_OFS_DATA   = 6'h1d;
   localparam logic [5:0] NVB_OFS_ADDR_L = 6'h1e;
   localparam logic [5:0] NVB_OFS_ADDR_H = 6'h1f;
   // control register field positions
   localparam int unsigned NVB_BIT_RD    = 0;
   localparam int unsigned NVB_BIT_WR    = 1;
   localparam int unsigned NVB_BIT_MWE   = 2;
   localparam logic [7:0] NVB_CTRL_RST   = 8'h00;
   localparam logic [7:0] NVB_DATA_RST   = 8'h00;
   // stall and enable windows in core clock cycles
   localparam logic [2:0] NVB_RD_STALL   = 3'h4;
   localparam logic [2:0] NVB_WR_STALL   = 3'h2;
   localparam logic [2:0] NVB_MWE_WIN    = 3'h4;
   // write timing
   localparam int unsigned NVB_SYS_HZ    = 100_000_000;
   localparam int unsigned NVB_OSC_HZ    = 1_000_000;
   localparam int unsigned NVB_OSC_DIV   = NVB_SYS_HZ / NVB_OSC_HZ;
   localparam int unsigned NVB_WR_OSC_CYC = 8448;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [5:0] addr;
      logic [7:0] wdata;
   } nvb_io_req_t;

   typedef struct packed {
      logic       stall;
      logic [7:0] rdata;
   } nvb_io_rsp_t;
endpackage

/* core/nvb_tick.sv */
// 1 MHz enable pulse for write timing, free running
module nvb_tick
   import nvb_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic srst,
   output logic      tick
);
   localparam logic [6:0] LAST = 7'(NVB_OSC_DIV - 1);
   logic [6:0] cnt_reg;
   logic [6:0] cnt_next;

   assign cnt_next = (cnt_reg == LAST) ? 7'h00 : cnt_reg + 7'h01;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt_reg <= 7'h00;
         tick    <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick    <= (cnt_reg == LAST);
      end
   end
endmodule

/* core/nvb_store.sv */
// byte store, one byte per access, flip-flop array
module nvb_store
   import nvb_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  we,
   input  wire logic [NVB_AW-1:0]     addr,
   input  wire logic [7:0]            wdata,
   output logic      [7:0]            rdata
);
   logic [7:0] mem [NVB_DEPTH];

   // linear map, 0..511 each distinct
   assign rdata = mem[addr];

   // no reset: contents are nonvolatile
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end
endmodule

/* core/nvb_unit.sv */
// byte access unit: i/o registers, stall, enable sequence, write timer
module nvb_unit
   import nvb_pkg::*;
#(
   parameter int unsigned WR_OSC_CYC = NVB_WR_OSC_CYC
)
(
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  nvb_pkg::nvb_io_req_t io_req,
   output nvb_pkg::nvb_io_rsp_t io_rsp,
   output logic             write_busy
);
   import nvb_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // register state
   logic [NVB_AW-1:0] nv_address_reg;
   logic [7:0]        nv_data_byte_reg;
   logic              mwe_reg;
   logic [2:0]        mwe_cnt_reg;
   logic              wstrobe_reg;
   logic [2:0]        stall_reg;
   logic [13:0]       wtime_reg;
   logic [7:0]        rdata_reg;
   logic [7:0]        store_q;
   logic              tick;
   logic              store_we;

   ////////////////////////////////////////////////////////////////////
   // decode of core accesses
   wire hit_ctrl  = io_req.addr == NVB_OFS_CTRL;
   wire hit_data  = io_req.addr == NVB_OFS_DATA;
   wire hit_addrl = io_req.addr == NVB_OFS_ADDR_L;
   wire hit_addrh = io_req.addr == NVB_OFS_ADDR_H;
   wire wr_ctrl   = io_req.wr_en & hit_ctrl;
   wire set_mwe   = wr_ctrl & io_req.wdata[NVB_BIT_MWE];
   wire set_wr    = wr_ctrl & io_req.wdata[NVB_BIT_WR];
   wire set_rd    = wr_ctrl & io_req.wdata[NVB_BIT_RD];
   // address frozen while a write runs
   wire addr_lock = wstrobe_reg;
   // a write starts only inside the master-enable window
   wire wr_start  = set_wr & mwe_reg & ~wstrobe_reg;
   // reads refused during a write
   wire rd_start  = set_rd & ~wstrobe_reg & ~set_wr;
   wire wr_done   = wstrobe_reg & tick & (wtime_reg == 14'h0001);
   wire stalled   = stall_reg != 3'h0;

   wire [7:0] ctrl_view = {5'h00, mwe_reg, wstrobe_reg, 1'b0};

   ////////////////////////////////////////////////////////////////////
   // byte store and write-timing tick
   assign store_we = wr_done;

   nvb_store u_store (
      .clk_sys (clk_sys),
      .we      (store_we),
      .addr    (nv_address_reg),
      .wdata   (nv_data_byte_reg),
      .rdata   (store_q)
   );

   nvb_tick u_tick (
      .clk_sys (clk_sys),
      .srst    (srst),
      .tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////
   // address register, no reset value
   always_ff @(posedge clk_sys) begin
      if (io_req.wr_en & hit_addrl & ~addr_lock) begin
         nv_address_reg[7:0] <= io_req.wdata;
      end
      // only bit 8 takes the high byte; upper bits stay zero
      if (io_req.wr_en & hit_addrh & ~addr_lock) begin
         nv_address_reg[8] <= io_req.wdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // data register: core write, or read load from the store
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         nv_data_byte_reg <= NVB_DATA_RST;
      end else if (rd_start) begin
         nv_data_byte_reg <= store_q;
      end else if (io_req.wr_en & hit_data & ~wstrobe_reg) begin
         nv_data_byte_reg <= io_req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // master write enable, self-clears four cycles after being set
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mwe_reg     <= NVB_CTRL_RST[NVB_BIT_MWE];
         mwe_cnt_reg <= 3'h0;
      end else if (set_mwe) begin
         mwe_reg     <= 1'b1;
         mwe_cnt_reg <= NVB_MWE_WIN;
      end else if (mwe_cnt_reg != 3'h0) begin
         mwe_cnt_reg <= mwe_cnt_reg - 3'h1;
         mwe_reg     <= mwe_cnt_reg != 3'h1;
      end else begin
         mwe_reg     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // write strobe held through the self-timed write
   // tick-based count: first tick may come early, so the write runs
   // between count-1 and count oscillator periods
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wstrobe_reg <= NVB_CTRL_RST[NVB_BIT_WR];
         wtime_reg   <= 14'h0000;
      end else if (wr_start) begin
         wstrobe_reg <= 1'b1;
         wtime_reg   <= 14'(WR_OSC_CYC);
      end else if (wr_done) begin
         wstrobe_reg <= 1'b0;
         wtime_reg   <= 14'h0000;
      end else if (wstrobe_reg & tick) begin
         wtime_reg   <= wtime_reg - 14'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // core stall counter
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stall_reg <= 3'h0;
      end else if (rd_start) begin
         stall_reg <= NVB_RD_STALL;
      end else if (wr_start) begin
         stall_reg <= NVB_WR_STALL;
      end else if (stalled) begin
         stall_reg <= stall_reg - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered read data; unmapped offsets read zero
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata_reg <= 8'h00;
      end else if (hit_ctrl) begin
         rdata_reg <= ctrl_view;
      end else if (hit_data) begin
         rdata_reg <= nv_data_byte_reg;
      end else if (hit_addrl) begin
         rdata_reg <= nv_address_reg[7:0];
      end else if (hit_addrh) begin
         rdata_reg <= {7'h00, nv_address_reg[8]};
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign io_rsp.stall = stalled;
   assign io_rsp.rdata = rdata_reg;
   assign write_busy   = wstrobe_reg;
endmodule

/* sim/nvb_core_model.sv */
// core side: issues i/o cycles, waits out stalls, polls writes
module nvb_core_model
   import nvb_pkg::*;
(
   input  wire logic           clk_sys,
   output nvb_pkg::nvb_io_req_t io_req,
   input  nvb_pkg::nvb_io_rsp_t io_rsp
);
   timeunit 1ns;
   timeprecision 1ns;
   initial io_req = '0;
   // one i/o write; data lines flip after release so stale data never helps
   task automatic wr(input logic [5:0] ofs, input logic [7:0] dat);
      @(negedge clk_sys);
      while (io_rsp.stall !== 1'b0) @(negedge clk_sys);
      io_req = '{1'b1, 1'b0, ofs, dat};
      @(negedge clk_sys);
      io_req.wr_en = 1'b0;
      io_req.wdata = ~dat;
   endtask
   task automatic rd(input logic [5:0] ofs, output logic [7:0] dat);
      @(negedge clk_sys);
      while (io_rsp.stall !== 1'b0) @(negedge clk_sys);
      io_req.addr = ofs;
      io_req.rd_en = 1'b1;
      @(negedge clk_sys);
      dat = io_rsp.rdata;
      io_req.rd_en = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // software routines
   task automatic poll();
      logic [7:0] c;
      do rd(NVB_OFS_CTRL, c); while (c[NVB_BIT_WR] !== 1'b0);
   endtask
   task automatic set_addr(input logic [8:0] a);
      wr(NVB_OFS_ADDR_H, {7'h00, a[8]});
      wr(NVB_OFS_ADDR_L, a[7:0]);
   endtask
   task automatic nv_write(input logic [8:0] a, input logic [7:0] dat);
      poll();
      set_addr(a);
      wr(NVB_OFS_DATA, dat);
      wr(NVB_OFS_CTRL, 8'h04);
      wr(NVB_OFS_CTRL, 8'h02);
   endtask
   task automatic nv_read(input logic [8:0] a, output logic [7:0] dat);
      poll();
      set_addr(a);
      wr(NVB_OFS_CTRL, 8'h01);
      rd(NVB_OFS_DATA, dat);
   endtask
endmodule

/* sim/nvb_unit_chk.sv */
module nvb_unit_chk
   import nvb_pkg::*;
#(
   parameter int unsigned WR_OSC_CYC = NVB_WR_OSC_CYC
)
(
   input  wire logic           clk_sys,
   input  wire logic           srst,
   input  nvb_pkg::nvb_io_req_t io_req,
   input  nvb_pkg::nvb_io_rsp_t io_rsp,
   input  wire logic           write_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BUSY_MAX = WR_OSC_CYC * NVB_OSC_DIV + 2;
   localparam int BUSY_MIN = (WR_OSC_CYC - 1) * NVB_OSC_DIV;
   wire ctrl_wr = io_req.wr_en && io_req.addr == NVB_OFS_CTRL;
   wire strobe_w = ctrl_wr && io_req.wdata[NVB_BIT_WR];
   logic [2:0]  mwe_age_reg;
   logic [19:0] busy_cnt_reg; // holds a full-length write at 100 MHz
   // age of the last enable, saturating so stale enables stay visible
   always_ff @(posedge clk_sys) begin
      if (srst || (ctrl_wr && io_req.wdata[NVB_BIT_MWE])) mwe_age_reg <= 3'h0;
      else if (mwe_age_reg != 3'h7) mwe_age_reg <= mwe_age_reg + 3'h1;
      busy_cnt_reg <= (srst || !write_busy) ? 20'h0 : busy_cnt_reg + 20'h1;
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   a_rd_stall_len: assert property (
      ctrl_wr && io_req.wdata[NVB_BIT_RD] && !io_req.wdata[NVB_BIT_WR] &&
      !write_busy && !io_rsp.stall |=> io_rsp.stall [*4] ##1 !io_rsp.stall)
      else $error("read stall length wrong");
   a_wr_stall_len: assert property (
      $rose(write_busy) |-> io_rsp.stall [*2] ##1 !io_rsp.stall)
      else $error("write stall length wrong");
   a_wr_needs_strobe: assert property (
      $rose(write_busy) |-> $past(strobe_w)) else $error("write w/o strobe");
   a_mwe_window: assert property (
      $rose(write_busy) |-> mwe_age_reg <= 3'h4) else $error("stale enable");
   a_ctrl_busy: assert property (
      io_req.addr == NVB_OFS_CTRL && !io_req.wr_en && $stable(write_busy)
      |=> io_rsp.rdata[NVB_BIT_WR] == $past(write_busy))
      else $error("strobe bit differs from busy");
   a_addr_high_zero: assert property (
      io_req.addr == NVB_OFS_ADDR_H |=> io_rsp.rdata[7:1] == 7'h00)
      else $error("reserved address bits set");
   a_rd_refused: assert property (
      ctrl_wr && io_req.wdata[NVB_BIT_RD] && write_busy && !io_rsp.stall
      |=> !io_rsp.stall) else $error("read accepted mid-write");
   a_busy_max: assert property (
      busy_cnt_reg <= BUSY_MAX) else $error("write too long");
   a_busy_min: assert property (
      $fell(write_busy) |-> $past(busy_cnt_reg) >= BUSY_MIN)
      else $error("write too short");
   cover property ($rose(write_busy));
   cover property (ctrl_wr && io_req.wdata[NVB_BIT_RD] && !write_busy);
   cover property (strobe_w && mwe_age_reg == 3'h7);
endmodule
bind nvb_unit nvb_unit_chk #(.WR_OSC_CYC(WR_OSC_CYC)) nvb_unit_chk_inst (
   .clk_sys(clk_sys), .srst(srst), .io_req(io_req), .io_rsp(io_rsp),
   .write_busy(write_busy));

/* sim/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import nvb_pkg::*;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   nvb_io_req_t io_req;
   nvb_io_rsp_t io_rsp;
   logic        write_busy;
   logic [7:0]  d;
   int          fails = 0;
   int          tests_run = 0;
   // rows: address and byte, ends and the high-bit boundary
   logic [8:0]  ta [5] = '{9'h000, 9'h001, 9'h0ff, 9'h100, 9'h1ff};
   logic [7:0]  td [5] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h81};
   always #5 clk_sys = ~clk_sys;
   // short write time keeps the run small
   nvb_unit #(.WR_OSC_CYC(4)) nvb_unit_inst (.clk_sys(clk_sys), .srst(srst),
      .io_req(io_req), .io_rsp(io_rsp), .write_busy(write_busy));
   nvb_core_model m (.clk_sys(clk_sys), .io_req(io_req), .io_rsp(io_rsp));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("mismatches %0d, comparisons %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #300000;
      fails++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys) srst = 1'b0;
      m.rd(NVB_OFS_CTRL, d); chk(d, NVB_CTRL_RST);
      m.rd(NVB_OFS_DATA, d); chk(d, NVB_DATA_RST);
      for (int i = 0; i < 5; i++) m.nv_write(ta[i], td[i]);
      m.rd(NVB_OFS_ADDR_H, d); chk(d, 8'h01);
      for (int i = 0; i < 5; i++) begin
         m.nv_read(ta[i], d);
         chk(d, td[i]);
      end
      m.wr(NVB_OFS_ADDR_H, 8'hff);
      m.rd(NVB_OFS_ADDR_H, d); chk(d, 8'h01);
      // strobe with no enable, then with an expired enable
      m.wr(NVB_OFS_DATA, 8'h77);
      m.wr(NVB_OFS_CTRL, 8'h02);
      m.rd(NVB_OFS_CTRL, d); chk(d, 8'h00);
      m.wr(NVB_OFS_CTRL, 8'h04);
      // strobe lands one cycle past the four-cycle window
      repeat (3) @(negedge clk_sys);
      m.wr(NVB_OFS_CTRL, 8'h02);
      m.rd(NVB_OFS_CTRL, d); chk(d, 8'h00);
      // address change and read attempted while a write runs
      m.nv_write(9'h0ff, 8'h99);
      m.rd(NVB_OFS_CTRL, d); chk(d, 8'h02);
      chk({7'h00, write_busy}, 8'h01);
      m.wr(NVB_OFS_ADDR_L, 8'h00);
      m.wr(NVB_OFS_CTRL, 8'h01);
      m.rd(NVB_OFS_DATA, d); chk(d, 8'h99);
      m.rd(NVB_OFS_ADDR_L, d); chk(d, 8'hff);
      m.nv_read(9'h0ff, d); chk(d, 8'h99);
      m.nv_read(9'h1ff, d); chk(d, td[4]);
      m.nv_read(9'h000, d); chk(d, td[0]);
      // strobe on the last cycle of the enable window is still taken
      m.set_addr(9'h005);
      m.wr(NVB_OFS_DATA, 8'h6e);
      m.wr(NVB_OFS_CTRL, 8'h04);
      repeat (2) @(negedge clk_sys);
      m.wr(NVB_OFS_CTRL, 8'h02);
      m.rd(NVB_OFS_CTRL, d); chk(d, 8'h02);
      m.nv_read(9'h005, d); chk(d, 8'h6e);
      conclude();
   end
endmodule
